// file: design/qdc_link_rx.sv
// Serial-clock side receiver: shifts frames in and hands complete words over.
`timescale 1ns/1ps
`default_nettype none

module qdc_link_rx (
	input wire logic sclk,
	input wire logic reset,
	input wire logic frame_sel_n,
	input wire logic sdata,
	output logic [15:0] frame_word,
	output logic frame_toggle
);

	logic [15:0] shift;
	logic [4:0] count;

	// ****************************************************************
	// Bit counter and shifter
	// ****************************************************************
	// The select high clears the count at once, because the serial clock
	// may stand still while the select is high.
	// shift on falling
	always_ff @(negedge sclk or posedge frame_sel_n) begin
		if (frame_sel_n) begin
			count <= 5'h00;
			shift <= qdc_pkg::RST_WORD;
		end else if (count != qdc_pkg::FRAME_DONE) begin
			shift <= {shift[14:0], sdata};
			count <= count + 5'h01;
		end
	end

	// ****************************************************************
	// Word capture on the sixteenth edge
	// ****************************************************************
	// A frame cut short never clocks an edge at the last count, so nothing is handed over.
	// capture sixteenth bit
	always_ff @(negedge sclk or posedge reset) begin
		if (reset) begin
			frame_word <= qdc_pkg::RST_WORD;
			frame_toggle <= 1'b0;
		end else if (!frame_sel_n && count == qdc_pkg::FRAME_LAST) begin
			frame_word <= {shift[14:0], sdata};
			frame_toggle <= ~frame_toggle;
		end
	end

endmodule : qdc_link_rx
`default_nettype wire

// file: design/qdc_quad_dac_ctrl.sv
// Top level of the quad converter control: frame execution, channel registers, bus slave.
// What this block does
// - Frame starts with select low; one data bit shifts in per falling clock.
// - Sixteenth falling edge takes last bit and executes the command.
// - Clocks and data after the sixteenth edge are ignored until select rises.
// - Frame is channel address, mode, ten data bits and two unused bits, first bit most significant.
// - Modes: load one, load one and update, load all and update, power down.
// - Output codes are plain unsigned binary from 0 to 1023.
// - Select rising early discards the frame with no change anywhere.
// - Reset sets state to ST_WAIT, clears all else but the link shifter and bit count, which select high clears; outputs stay zero until a valid frame.
// - Mode 11 powers down all channels whatever the address holds.
// - In power-down address picks termination: high-Z, 2.5k or 100k.
// - Power-down keeps channel registers unchanged.
// - Any other mode leaves power-down from that frame's sixteenth edge.
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module qdc_quad_dac_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic frame_sel_n,
	input wire logic sdata,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [9:0] code_a,
	output logic [9:0] code_b,
	output logic [9:0] code_c,
	output logic [9:0] code_d,
	output logic outputs_powered_down,
	output logic [1:0] out_term
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [9:0] frame_code(input logic [15:0] word);
		frame_code = word[qdc_pkg::CODE_HI:qdc_pkg::CODE_LO];
	endfunction : frame_code

	function automatic logic [1:0] term_of(input logic [1:0] sel);
		case (sel)
			qdc_pkg::SEL_TERM_2K5: term_of = qdc_pkg::TERM_2K5;
			qdc_pkg::SEL_TERM_100K: term_of = qdc_pkg::TERM_100K;
			default: term_of = qdc_pkg::TERM_HIZ;
		endcase
	endfunction : term_of

	// ****************************************************************
	// Link domain
	// ****************************************************************
	logic [15:0] link_word;
	logic link_toggle;

	qdc_link_rx u_link_rx (
		.sclk(sclk),
		.reset(reset),
		.frame_sel_n(frame_sel_n),
		.sdata(sdata),
		.frame_word(link_word),
		.frame_toggle(link_toggle)
	);

	// ****************************************************************
	// Frame event crossing
	// ****************************************************************
	// The word is held stable for at least sixteen serial clocks after the
	// toggle flips, far longer than the three system clocks needed here,
	// so it may be read once the synchronised toggle shows the event.
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic link_evt;

	always_ff @(posedge clk) begin
		if (reset) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
		end else begin
			tog_s1 <= link_toggle;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
		end
	end

	assign link_evt = tog_s2 ^ tog_s3;

	// ****************************************************************
	// Bus slave request decode
	// ****************************************************************
	logic wb_req;
	logic wr_cmd;
	logic sw_pend;
	logic [15:0] sw_word;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_cmd = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (wb_adr_i == qdc_pkg::ADR_CMD);

	// ****************************************************************
	// Software command word
	// ****************************************************************
	// A written word runs as if it arrived on the link; a link frame in the
	// same cycle goes first and the software word runs one cycle later.
	always_ff @(posedge clk) begin
		if (reset) begin
			sw_word <= qdc_pkg::RST_WORD;
		end else if (wr_cmd) begin
			if (wb_sel_i[0]) begin
				sw_word[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				sw_word[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sw_pend <= 1'b0;
		end else begin
			sw_pend <= wr_cmd | (sw_pend & link_evt);
		end
	end

	// ****************************************************************
	// Command execution
	// ****************************************************************
	logic exec_go;
	logic [15:0] exec_word;
	logic [1:0] ex_chan;
	logic [1:0] ex_mode;
	logic [9:0] ex_code;

	assign exec_go = link_evt | sw_pend;
	assign exec_word = link_evt ? link_word : sw_word;
	assign ex_chan = exec_word[qdc_pkg::CHAN_HI:qdc_pkg::CHAN_LO];
	assign ex_mode = exec_word[qdc_pkg::MODE_HI:qdc_pkg::MODE_LO];
	assign ex_code = frame_code(exec_word);

	logic [9:0] in_reg [0:3];
	logic [9:0] out_code [0:3];

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < qdc_pkg::NUM_CHAN; i++) begin
				in_reg[i] <= qdc_pkg::RST_CODE;
			end
		end else if (exec_go) begin
			case (ex_mode)
				qdc_pkg::MODE_LOAD_ONE, qdc_pkg::MODE_LOAD_UPD: begin
					in_reg[ex_chan] <= ex_code;
				end
				qdc_pkg::MODE_LOAD_ALL: begin
					for (int i = 0; i < qdc_pkg::NUM_CHAN; i++) begin
						in_reg[i] <= ex_code;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Codes are carried as plain unsigned binary to the converter inputs.
	// binary output codes
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < qdc_pkg::NUM_CHAN; i++) begin
				out_code[i] <= qdc_pkg::RST_CODE;
			end
		end else if (exec_go) begin
			case (ex_mode)
				qdc_pkg::MODE_LOAD_UPD: begin
					for (int i = 0; i < qdc_pkg::NUM_CHAN; i++) begin
						out_code[i] <= (ex_chan == 2'(i)) ? ex_code : in_reg[i];
					end
				end
				qdc_pkg::MODE_LOAD_ALL: begin
					for (int i = 0; i < qdc_pkg::NUM_CHAN; i++) begin
						out_code[i] <= ex_code;
					end
				end
				default: begin
				end
			endcase
		end
	end

	assign code_a = out_code[0];
	assign code_b = out_code[1];
	assign code_c = out_code[2];
	assign code_d = out_code[3];

	// ****************************************************************
	// Power state
	// ****************************************************************
	qdc_pkg::qdc_state_t state;

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= qdc_pkg::ST_WAIT;
			outputs_powered_down <= 1'b0;
			out_term <= qdc_pkg::TERM_HIZ;
		end else if (exec_go) begin
			case (ex_mode)
				qdc_pkg::MODE_PDOWN: begin
					state <= qdc_pkg::ST_PDOWN;
					outputs_powered_down <= 1'b1;
					out_term <= term_of(ex_chan);
				end
				default: begin
					state <= qdc_pkg::ST_ACTIVE;
					outputs_powered_down <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Executed frame counter
	// ****************************************************************
	logic [7:0] frame_count;

	always_ff @(posedge clk) begin
		if (reset) begin
			frame_count <= qdc_pkg::RST_COUNT;
		end else if (exec_go) begin
			frame_count <= frame_count + 8'h01;
		end
	end

	// ****************************************************************
	// Bus slave read path and acknowledge
	// ****************************************************************
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = qdc_pkg::RST_RDATA;
		if (wb_adr_i == qdc_pkg::ADR_CMD) begin
			next_rdata[15:0] = sw_word;
		end else if (wb_adr_i == qdc_pkg::ADR_STATUS) begin
			next_rdata[qdc_pkg::ST_PEND_BIT] = sw_pend;
			next_rdata[qdc_pkg::ST_STATE_LO +: 3] = state;
			next_rdata[qdc_pkg::ST_TERM_LO +: 2] = out_term;
			next_rdata[qdc_pkg::ST_COUNT_LO +: 8] = frame_count;
		end else if (wb_adr_i[1:0] == 2'h0) begin
			case (wb_adr_i[7:4])
				qdc_pkg::ADR_IN_PAGE: next_rdata[9:0] = in_reg[wb_adr_i[3:2]];
				qdc_pkg::ADR_OUT_PAGE: next_rdata[9:0] = out_code[wb_adr_i[3:2]];
				default: next_rdata = qdc_pkg::RST_RDATA;
			endcase
		end
	end

	// Every address is answered so that a stray access never hangs the bus.
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= qdc_pkg::RST_RDATA;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

endmodule : qdc_quad_dac_ctrl
`default_nettype wire

// file: dv/qdc_host_model.sv
// Host serial master model that sends frames to the converter control.
`timescale 1ns/1ps
`default_nettype none

module qdc_host_model (
	output logic sclk,
	output logic frame_sel_n,
	output logic sdata
);
	// Non-blocking at time zero so that the receiver sees the select rise and clears its count.
	initial begin
		sclk <= 1'b1;
		frame_sel_n <= 1'b1;
		sdata <= 1'b0;
	end

	// The serial clock only runs inside a frame and rests high between them.
	// The select idles low to save input current, so it is raised before each frame.
	task automatic send(input logic [15:0] word, input int edges, input int extra);
		int i;
		frame_sel_n = 1'b1;
		#64;
		frame_sel_n = 1'b0;
		#13;
		for (i = 0; i < edges + extra; i++) begin
			sdata = (i < 16) ? word[15 - i] : ~sdata;
			#16;
			sclk = 1'b0;
			#32;
			sclk = 1'b1;
			#16;
		end
		sdata = 1'b0;
		frame_sel_n = 1'b1;
		#64;
		frame_sel_n = 1'b0;
		#64;
	endtask : send
endmodule : qdc_host_model
`default_nettype wire

// file: dv/qdc_quad_dac_ctrl_bench.sv
// Self-checking bench of the quad converter control block.
`timescale 1ns/1ps
`default_nettype none

module qdc_quad_dac_ctrl_bench;
	logic clk = 1'b0;
	logic reset;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, sclk, frame_sel_n, sdata, outputs_powered_down;
	logic [9:0] code_a, code_b, code_c, code_d;
	logic [1:0] out_term;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;

	always #4 clk = ~clk;

	qdc_host_model u_host (.sclk, .frame_sel_n, .sdata);
	qdc_quad_dac_ctrl u_dut (.clk, .reset, .sclk, .frame_sel_n, .sdata, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .code_a, .code_b, .code_c, .code_d, .outputs_powered_down,
		.out_term);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] fw(input logic [1:0] ch, input logic [1:0] md, input logic [9:0] c);
		return {ch, md, c, 2'b11};
	endfunction : fw

	function automatic logic [39:0] codes();
		return {code_d, code_c, code_b, code_a};
	endfunction : codes

	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_modes();
		check(codes(), 40'h00_0000_0000);
		wb(1'b0, qdc_pkg::ADR_STATUS, 32'h0000_0000);
		check({8'h00, rd}, 40'h00_0000_0002);
		u_host.send(fw(2'h0, qdc_pkg::MODE_LOAD_ONE, 10'h155), 16, 0);
		check(codes(), 40'h00_0000_0000);
		wb(1'b0, 8'h10, 32'h0000_0000);
		check({8'h00, rd}, 40'h00_0000_0155);
		u_host.send(fw(2'h1, qdc_pkg::MODE_LOAD_UPD, 10'h2AA), 16, 5);
		check(codes(), {10'h000, 10'h000, 10'h2AA, 10'h155});
		u_host.send(fw(2'h3, qdc_pkg::MODE_LOAD_ALL, 10'h3FF), 16, 0);
		check(codes(), {4{10'h3FF}});
		u_host.send(fw(2'h0, qdc_pkg::MODE_LOAD_UPD, 10'h000), 15, 0);
		check(codes(), {4{10'h3FF}});
		wb(1'b0, qdc_pkg::ADR_STATUS, 32'h0000_0000);
		check({8'h00, rd}, 40'h00_0000_0304);
		$display("test modes done");
	endtask : t_modes

	task automatic t_pdown();
		logic [1:0] term;
		for (int i = 0; i < 4; i++) begin
			term = (i == 1) ? qdc_pkg::TERM_2K5 : (i == 2) ? qdc_pkg::TERM_100K : qdc_pkg::TERM_HIZ;
			u_host.send(fw(i[1:0], qdc_pkg::MODE_PDOWN, 10'h0A5), 16, 0);
			check({37'h0, outputs_powered_down, out_term}, {37'h0, 1'b1, term});
			check(codes(), {4{10'h3FF}});
			wb(1'b0, qdc_pkg::ADR_STATUS, 32'h0000_0000);
			check({8'h00, rd}, {24'h00_0000, 8'(4 + i), 2'b00, term, 4'h8});
		end
		u_host.send(fw(2'h2, qdc_pkg::MODE_LOAD_ONE, 10'h0F0), 16, 0);
		check({39'h0, outputs_powered_down}, 40'h00_0000_0000);
		wb(1'b0, qdc_pkg::ADR_STATUS, 32'h0000_0000);
		check({8'h00, rd}, 40'h00_0000_0804);
		$display("test power-down done");
	endtask : t_pdown

	task automatic t_bus();
		wb(1'b0, 8'h08, 32'h0000_0000);
		check({8'h00, rd}, 40'h00_0000_0000);
		wb(1'b1, qdc_pkg::ADR_CMD, {16'h0000, fw(2'h0, qdc_pkg::MODE_LOAD_UPD, 10'h001)});
		repeat (4) @(posedge clk);
		check(codes(), {10'h3FF, 10'h0F0, 10'h3FF, 10'h001});
		wb(1'b0, 8'h20, 32'h0000_0000);
		check({8'h00, rd}, 40'h00_0000_0001);
		$display("test bus done");
	endtask : t_bus

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_modes();
		t_pdown();
		t_bus();
		results();
	end
endmodule : qdc_quad_dac_ctrl_bench
`default_nettype wire

// file: dv/qdc_quad_dac_ctrl_monitor.sv
// Port-level assertions of the quad converter control block.
`timescale 1ns/1ps
`default_nettype none

module qdc_quad_dac_ctrl_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [9:0] code_a,
	input wire logic [9:0] code_b,
	input wire logic [9:0] code_c,
	input wire logic [9:0] code_d,
	input wire logic outputs_powered_down,
	input wire logic [1:0] out_term
);
	wire logic [39:0] codes;
	assign codes = {code_d, code_c, code_b, code_a};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_RESET_CLEAR:
	assert property ($fell(reset) |-> codes == 40'h0 && !outputs_powered_down && out_term == 2'h0)
		else $error("outputs not cleared by reset");
	AST_ACK_PULSE:
	assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	AST_ACK_CAUSE:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
	AST_ACK_ONLY:
	assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	AST_UNMAPPED_ZERO:
	assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_STATUS_TERM:
	assert property (wb_ack_o && !wb_we_i && wb_adr_i == qdc_pkg::ADR_STATUS |->
		wb_dat_o[5:4] == $past(out_term) && wb_dat_o[3] == $past(outputs_powered_down))
		else $error("status disagrees with outputs");
	AST_OUT_CODE:
	assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o[9:0] == $past(code_a))
		else $error("output code readback wrong");
	AST_TERM_IN_PDOWN:
	assert property ($changed(out_term) |-> outputs_powered_down) else $error("termination changed while active");
	AST_PDOWN_HOLD:
	assert property (outputs_powered_down && $past(outputs_powered_down) |-> $stable(codes))
		else $error("codes changed in power-down");
	AST_CODE_ACTIVE:
	assert property ($changed(codes) |-> !outputs_powered_down) else $error("codes changed entering power-down");
endmodule : qdc_quad_dac_ctrl_monitor

bind qdc_quad_dac_ctrl qdc_quad_dac_ctrl_monitor u_mon (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .code_a, .code_b, .code_c, .code_d, .outputs_powered_down, .out_term);
`default_nettype wire

// file: pkg/qdc_pkg.sv
// Shared constants and types of the quad converter serial control block.
package qdc_pkg;

	// ****************************************************************
	// Frame layout
	// ****************************************************************
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	localparam logic [4:0] FRAME_DONE = 5'h10;
	localparam int CHAN_HI = 15;
	localparam int CHAN_LO = 14;
	localparam int MODE_HI = 13;
	localparam int MODE_LO = 12;
	localparam int CODE_HI = 11;
	localparam int CODE_LO = 2;
	localparam int CODE_BITS = 10;
	localparam int NUM_CHAN = 4;

	// ****************************************************************
	// Operating modes and power-down terminations
	// ****************************************************************
	localparam logic [1:0] MODE_LOAD_ONE = 2'h0;
	localparam logic [1:0] MODE_LOAD_UPD = 2'h1;
	localparam logic [1:0] MODE_LOAD_ALL = 2'h2;
	localparam logic [1:0] MODE_PDOWN = 2'h3;
	localparam logic [1:0] SEL_TERM_2K5 = 2'h1;
	localparam logic [1:0] SEL_TERM_100K = 2'h2;
	localparam logic [1:0] TERM_HIZ = 2'h0;
	localparam logic [1:0] TERM_2K5 = 2'h1;
	localparam logic [1:0] TERM_100K = 2'h2;

	// ****************************************************************
	// Power state, one-hot
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_ACTIVE = 3'b010,
		ST_PDOWN = 3'b100
	} qdc_state_t;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [3:0] ADR_IN_PAGE = 4'h1;
	localparam logic [3:0] ADR_OUT_PAGE = 4'h2;
	localparam int ST_PEND_BIT = 0;
	localparam int ST_STATE_LO = 1;
	localparam int ST_TERM_LO = 4;
	localparam int ST_COUNT_LO = 8;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [9:0] RST_CODE = 10'h000;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage : qdc_pkg
